/* File: common/adcss_cfg.svh */
// offsets, field positions, reset values of the single sweep sequencer
`ifndef ADCSS_CFG_SVH
`define ADCSS_CFG_SVH

// ********************************************************************
// widths
// ********************************************************************
`define ADCSS_CODE_W     10
`define ADCSS_ADDR_W     10
`define ADCSS_RDATA_W    16

// ********************************************************************
// register byte addresses
// ********************************************************************
`define ADCSS_CTRL0_OFS  10'h3D6
`define ADCSS_CTRL1_OFS  10'h3D7
`define ADCSS_STAT_OFS   10'h3D0
`define ADCSS_MASK_OFS   10'h3D1
`define ADCSS_RES_BASE   10'h3C0

// ********************************************************************
// reset values
// ********************************************************************
`define ADCSS_CTRL0_RST  8'h00
`define ADCSS_CTRL1_RST  8'h00

// ********************************************************************
// field positions
// ********************************************************************
`define ADCSS_C0_INSEL   2:0
`define ADCSS_C0_MODE    4:3
`define ADCSS_C0_START   6
`define ADCSS_C0_FREQ    7
`define ADCSS_C1_GROUP   1:0
`define ADCSS_C1_EXT     2
`define ADCSS_C1_NOBIT   3
`define ADCSS_C1_FREQ    4
`define ADCSS_C1_STBY    5
`define ADCSS_MODE_SGL   2'h2
`define ADCSS_EV_DONE    0

`endif

/* File: common/adcss_pkg.sv */
// types shared by the single sweep sequencer files
`include "adcss_cfg.svh"
package adcss_pkg;
	// sequencer states
	typedef enum logic [1:0] {ADCSS_IDLE, ADCSS_ISSUE, ADCSS_WAIT} adcss_state_t;
	// register port request from software
	typedef struct packed {
		logic [`ADCSS_ADDR_W-1:0] addr;
		logic [7:0]               wdata;
		logic                     wr;
		logic                     rd;
	} adcss_bus_t;
	// conversion request to the analog core
	typedef struct packed {
		logic       go;
		logic [2:0] pin;
	} adcss_req_t;
	// conversion answer from the analog core
	typedef struct packed {
		logic                     valid;
		logic [`ADCSS_CODE_W-1:0] code;
	} adcss_rsp_t;
endpackage

/* File: rtl/adcss_res_bank.sv */
// per-pin result store, one word for each analog input
module adcss_res_bank
	import adcss_pkg::*;
#(
	parameter int W = 10,
	parameter int N = 8
) (
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	input  wire logic                 wr_en,
	input  wire logic [$clog2(N)-1:0] wr_idx,
	input  wire logic [W-1:0]         wr_data,
	input  wire logic [$clog2(N)-1:0] rd_idx,
	output logic      [W-1:0]         rd_data
);
	logic [W-1:0] mem [N];  // one result word per pin

	// ****************************************************************
	// storage
	// ****************************************************************
	// cleared at reset so reads before a sweep are not unknown
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < N; i++) begin
				mem[i] <= '0;
			end
		end else if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	assign rd_data = mem[rd_idx];

	slot_write_a: assert property (@(posedge core_clk) disable iff (reset)
		wr_en |=> mem[$past(wr_idx)] == $past(wr_data))
		else $error("result slot not written");
endmodule

/* File: rtl/adcss_irq.sv */
// sticky event status, mask and level interrupt
module adcss_irq
	import adcss_pkg::*;
#(
	parameter int EV_W = 1
) (
	input  wire logic            core_clk,
	input  wire logic            reset,
	input  wire logic [EV_W-1:0] ev,
	input  wire logic            wr_stat,
	input  wire logic            wr_mask,
	input  wire logic [EV_W-1:0] wdata,
	output logic      [EV_W-1:0] stat_r,
	output logic      [EV_W-1:0] mask_r,
	output logic                 irq_r
);
	// ****************************************************************
	// status: write one to clear, a new event wins over the clear
	// ****************************************************************
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			stat_r <= '0;
		end else begin
			stat_r <= (stat_r & ~({EV_W{wr_stat}} & wdata)) | ev;
		end
	end

	// mask: a one lets the status bit reach the interrupt
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mask_r <= '0;
		end else if (wr_mask) begin
			mask_r <= wdata;
		end
	end

	// level output, registered so it comes straight from a flop
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(stat_r & mask_r);
		end
	end

	event_kept_a: assert property (@(posedge core_clk) disable iff (reset)
		|ev |=> (stat_r & $past(ev)) == $past(ev))
		else $error("event lost against clear");
endmodule

/* File: rtl/adcss_top.sv */
// single sweep sequencer: registers, sweep control and core handshake
`include "adcss_cfg.svh"

module adcss_top
	import adcss_pkg::*;
#(
	parameter int CODE_W = `ADCSS_CODE_W
) (
	input  wire logic                      core_clk,
	input  wire logic                      reset,
	input  wire adcss_bus_t                bus,
	output logic      [`ADCSS_RDATA_W-1:0] bus_rdata,
	output adcss_req_t                     conv_req,
	input  wire adcss_rsp_t                conv_rsp,
	output logic                           converter_standby_enable,
	output logic      [1:0]                freq_sel,
	output logic                           irq
);
	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [7:0]                ctrl0_r;      // first control register
	logic [7:0]                ctrl1_r;      // second control register
	adcss_state_t              state_r;      // sweep sequencer state
	adcss_state_t              state_nxt;    // its next value
	logic [2:0]                pin_r;        // pin being converted
	logic [2:0]                pin_nxt;      // its next value
	adcss_req_t                req_r;        // request to the core
	logic [`ADCSS_RDATA_W-1:0] rdata_r;      // read answer
	logic [`ADCSS_RDATA_W-1:0] rd_val;       // read mux result
	logic                      wr_c0;        // write to first control
	logic                      wr_c1;        // write to second control
	logic                      wr_stat;      // write to status
	logic                      wr_mask;      // write to mask
	logic                      start_take;   // sweep begins
	logic                      abort;        // sweep stopped by software
	logic                      res_hit;      // result window addressed
	logic                      res_store;    // core answer accepted
	logic                      sweep_done;   // last pin stored
	logic [2:0]                last_pin;     // highest pin of the group
	logic [CODE_W-1:0]         res_rd;       // result bank read word
	logic [0:0]                stat_w;       // interrupt status
	logic [0:0]                mask_w;       // interrupt mask
	logic                      irq_w;        // interrupt level

	// highest pin number that a group code covers
	function automatic logic [2:0] group_last(input logic [1:0] g);
		group_last = {g, 1'b1};
	endfunction

	// true when a byte address equals a register offset
	function automatic logic hit(
		input logic [`ADCSS_ADDR_W-1:0] a,
		input logic [`ADCSS_ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	// ****************************************************************
	// address decode
	// ****************************************************************
	assign wr_c0   = bus.wr && hit(bus.addr, `ADCSS_CTRL0_OFS);
	assign wr_c1   = bus.wr && hit(bus.addr, `ADCSS_CTRL1_OFS);
	assign wr_stat = bus.wr && hit(bus.addr, `ADCSS_STAT_OFS);
	assign wr_mask = bus.wr && hit(bus.addr, `ADCSS_MASK_OFS);
	// results sit on even addresses, two bytes apart
	assign res_hit = (bus.addr[9:4] == 6'(`ADCSS_RES_BASE >> 4)) &&
	                 !bus.addr[0];

	// ****************************************************************
	// sweep conditions
	// ****************************************************************
	assign last_pin = group_last(ctrl1_r[`ADCSS_C1_GROUP]);
	// a start needs sweep mode in the same write and the converter
	// enabled; a write of one while busy does not restart
	assign start_take = wr_c0 && bus.wdata[`ADCSS_C0_START] &&
	                    (bus.wdata[`ADCSS_C0_MODE] == `ADCSS_MODE_SGL) &&
	                    ctrl1_r[`ADCSS_C1_STBY] &&
	                    (state_r == ADCSS_IDLE);
	assign abort      = wr_c0 && !bus.wdata[`ADCSS_C0_START];
	assign res_store  = (state_r == ADCSS_WAIT) && conv_rsp.valid &&
	                    !abort;
	assign sweep_done = res_store && (pin_r == last_pin);

	// ****************************************************************
	// first control register
	// ****************************************************************
	// a software write wins over the hardware clear of the start flag
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctrl0_r <= `ADCSS_CTRL0_RST;
		end else if (wr_c0) begin
			ctrl0_r <= bus.wdata;
		end else if (sweep_done) begin
			ctrl0_r[`ADCSS_C0_START] <= 1'b0;
		end
	end

	// ****************************************************************
	// second control register
	// ****************************************************************
	// bit three has no storage and reads zero; reserved bits keep
	// whatever software wrote, which should be zero
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctrl1_r <= `ADCSS_CTRL1_RST;
		end else if (wr_c1) begin
			ctrl1_r <= bus.wdata & ~(8'h01 << `ADCSS_C1_NOBIT);
		end
	end

	// ****************************************************************
	// sweep sequencer
	// ****************************************************************
	// control writes during a sweep are taken but do not restart it;
	// the result of the pin in flight is then not guaranteed
	always_comb begin
		state_nxt = state_r;
		pin_nxt   = pin_r;
		case (state_r)
			ADCSS_IDLE: begin
				if (start_take) begin
					state_nxt = ADCSS_ISSUE;
					pin_nxt   = 3'h0;
				end
			end
			ADCSS_ISSUE: begin
				state_nxt = ADCSS_WAIT;  // request goes out now
			end
			ADCSS_WAIT: begin
				if (res_store) begin
					if (pin_r == last_pin) begin
						state_nxt = ADCSS_IDLE;
					end else begin
						state_nxt = ADCSS_ISSUE;
						pin_nxt   = pin_r + 3'h1;
					end
				end
			end
			default: begin
				state_nxt = ADCSS_IDLE;
			end
		endcase
		if (abort) begin
			state_nxt = ADCSS_IDLE;
		end
	end

	// state and pin update
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_r <= ADCSS_IDLE;
			pin_r   <= 3'h0;
		end else begin
			state_r <= state_nxt;
			pin_r   <= pin_nxt;
		end
	end

	// one-cycle request pulse whenever a pin is about to convert
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			req_r <= '0;
		end else begin
			req_r.go  <= (state_nxt == ADCSS_ISSUE);
			req_r.pin <= pin_nxt;
		end
	end

	// ****************************************************************
	// result bank and interrupt
	// ****************************************************************
	adcss_res_bank #(
		.W (CODE_W),
		.N (8)
	) u_bank (
		.core_clk (core_clk),
		.reset    (reset),
		.wr_en    (res_store),
		.wr_idx   (pin_r),
		.wr_data  (conv_rsp.code),
		.rd_idx   (bus.addr[3:1]),
		.rd_data  (res_rd)
	);

	adcss_irq #(
		.EV_W (1)
	) u_irq (
		.core_clk (core_clk),
		.reset    (reset),
		.ev       (sweep_done),
		.wr_stat  (wr_stat),
		.wr_mask  (wr_mask),
		.wdata    (bus.wdata[`ADCSS_EV_DONE]),
		.stat_r   (stat_w),
		.mask_r   (mask_w),
		.irq_r    (irq_w)
	);

	// ****************************************************************
	// read port
	// ****************************************************************
	// unmapped addresses read zero; data stands only one cycle
	always_comb begin
		rd_val = '0;
		if (hit(bus.addr, `ADCSS_CTRL0_OFS)) begin
			rd_val[7:0] = ctrl0_r;
		end else if (hit(bus.addr, `ADCSS_CTRL1_OFS)) begin
			rd_val[7:0] = ctrl1_r;
		end else if (hit(bus.addr, `ADCSS_STAT_OFS)) begin
			rd_val[0] = stat_w[0];
		end else if (hit(bus.addr, `ADCSS_MASK_OFS)) begin
			rd_val[0] = mask_w[0];
		end else if (res_hit) begin
			rd_val[CODE_W-1:0] = res_rd;
		end
	end

	// read answer register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= bus.rd ? rd_val : '0;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign bus_rdata                = rdata_r;
	assign conv_req                 = req_r;
	assign converter_standby_enable = ctrl1_r[`ADCSS_C1_STBY];
	assign freq_sel = {ctrl1_r[`ADCSS_C1_FREQ], ctrl0_r[`ADCSS_C0_FREQ]};
	assign irq                      = irq_w;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	sweep_start_a: assert property (
		start_take |=> req_r.go && req_r.pin == 3'h0 ##1
		state_r == ADCSS_WAIT)
		else $error("sweep did not start at pin zero");

	pin_order_a: assert property (
		res_store && pin_r != last_pin |=>
		req_r.go && req_r.pin == $past(pin_r) + 3'h1)
		else $error("next pin not in ascending order");

	flag_clear_a: assert property (
		sweep_done && !wr_c0 |=> !ctrl0_r[`ADCSS_C0_START] &&
		state_r == ADCSS_IDLE)
		else $error("start flag not cleared at end");

	sweep_abort_a: assert property (
		abort |=> state_r == ADCSS_IDLE && !req_r.go)
		else $error("abort did not stop sweep");

	irq_cause_a: assert property (
		$rose(stat_w[0]) |-> $past(sweep_done))
		else $error("interrupt without sweep completion");

	group_end_a: assert property (
		sweep_done |-> pin_r == {ctrl1_r[1:0], 1'b1})
		else $error("sweep ended on wrong pin");

	mode_gate_a: assert property (
		wr_c0 && bus.wdata[`ADCSS_C0_MODE] != `ADCSS_MODE_SGL &&
		state_r == ADCSS_IDLE |=> state_r == ADCSS_IDLE)
		else $error("sweep started outside sweep mode");

	one_pulse_a: assert property (
		req_r.go |=> !req_r.go [*2])
		else $error("request pulse longer than one cycle");

	nobit_read_a: assert property (
		bus.rd && hit(bus.addr, `ADCSS_CTRL1_OFS) |=>
		bus_rdata[`ADCSS_C1_NOBIT] == 1'b0)
		else $error("unbuilt bit reads one");

	// ****************************************************************
	// read port and interrupt checks
	// ****************************************************************
	// the answer must drop back to zero so a stale word is never seen
	rdata_idle_a: assert property (
		!bus.rd |=> bus_rdata == '0)
		else $error("read data stands outside its cycle");

	// a result read returns the stored code with the upper bits zero
	result_read_a: assert property (
		bus.rd && res_hit |=> bus_rdata[CODE_W-1:0] == $past(res_rd) &&
		bus_rdata[`ADCSS_RDATA_W-1:CODE_W] == '0)
		else $error("result word read back wrong");

	// the level follows status and mask one cycle later
	irq_follow_a: assert property (
		irq == $past(stat_w[0] && mask_w[0]))
		else $error("interrupt level does not track status");

	// a finished sweep must leave its mark in the status bit
	done_status_a: assert property (
		sweep_done |=> stat_w[0])
		else $error("sweep end not recorded");

	// an abort must never look like a completion
	abort_quiet_a: assert property (
		abort |=> stat_w[0] == $past(stat_w[0]))
		else $error("abort changed the status bit");

	// ****************************************************************
	// sequencer checks
	// ****************************************************************
	// the converter must stay quiet while in standby
	standby_gate_a: assert property (
		wr_c0 && !ctrl1_r[`ADCSS_C1_STBY] && state_r == ADCSS_IDLE |=>
		state_r == ADCSS_IDLE && !req_r.go)
		else $error("sweep started in standby");

	// a request is only ever issued from the issue state
	go_issue_a: assert property (
		req_r.go |-> state_r == ADCSS_ISSUE)
		else $error("request outside issue state");

	// the pin must not move while its code is awaited
	pin_hold_a: assert property (
		state_r == ADCSS_WAIT && !res_store |=> $stable(req_r.pin))
		else $error("pin changed during conversion");

	// no request leaves an idle sequencer unless a start is taken
	idle_quiet_a: assert property (
		state_r == ADCSS_IDLE && !start_take |=> !req_r.go)
		else $error("request from idle without start");
endmodule

/* File: testbench/adcss_core_model.sv */
// stand-in for the analog converter core on the far side of the sequencer
`include "adcss_cfg.svh"
module adcss_core_model
	import adcss_pkg::*;
(
	input  wire logic                     core_clk,
	input  wire logic                     reset,
	input  wire adcss_req_t               conv_req,
	input  wire logic [3:0]               lat,
	input  wire logic [`ADCSS_CODE_W-1:0] base,
	output adcss_rsp_t                    conv_rsp
);
	timeunit 1ns;
	timeprecision 100ps;

	logic       busy_r;  // a conversion is in flight
	logic [3:0] cnt_r;   // cycles left before the answer
	logic [2:0] pin_r;   // pin being converted

	// ********************************************************************
	// conversion timing
	// ********************************************************************
	// the answer comes lat+1 cycles after the request; lat 0 is prompt
	// the code lines flip outside valid so a stale code is never trusted
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			busy_r   <= 1'b0;
			cnt_r    <= 4'h0;
			pin_r    <= 3'h0;
			conv_rsp <= '0;
		end else begin
			conv_rsp.valid <= 1'b0;
			conv_rsp.code  <= ~conv_rsp.code;
			if (conv_req.go) begin
				// new request: latch pin, start the delay
				busy_r <= 1'b1;
				cnt_r  <= lat;
				pin_r  <= conv_req.pin;
			end else if (busy_r && cnt_r == 4'h0) begin
				// code of a pin is the sweep offset plus its number
				busy_r         <= 1'b0;
				conv_rsp.valid <= 1'b1;
				conv_rsp.code  <= base + {7'h00, pin_r};
			end else if (busy_r) begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end
endmodule

/* File: testbench/adc_single_sweep_sequencer_test.sv */
// self-checking bench of the single sweep sequencer
`include "adcss_cfg.svh"
module adc_single_sweep_sequencer_test
	import adcss_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic                      core_clk;
	logic                      reset;
	adcss_bus_t                bus_s;      // register port request
	logic [`ADCSS_RDATA_W-1:0] bus_rdata;
	adcss_req_t                conv_req;
	adcss_rsp_t                conv_rsp;
	logic                      stby;
	logic [1:0]                freq;       // frequency select pins
	logic                      irq;
	logic [3:0]                lat;        // core answer delay
	logic [`ADCSS_CODE_W-1:0]  base;       // core code offset
	int                        error_cnt = 0;
	int                        checked = 0;
	int                        seed = 32'h8A87;
	logic [15:0]               rd_q[$];    // expected read data
	logic [2:0]                pin_q[$];   // expected conversion order
	logic                      rd_d;       // read taken at last edge
	logic                      irq_d;      // irq at last edge

	adcss_top dut_u (
		.core_clk                 (core_clk),
		.reset                    (reset),
		.bus                      (bus_s),
		.bus_rdata                (bus_rdata),
		.conv_req                 (conv_req),
		.conv_rsp                 (conv_rsp),
		.converter_standby_enable (stby),
		.freq_sel                 (freq),
		.irq                      (irq)
	);

	adcss_core_model core_u (
		.core_clk (core_clk),
		.reset    (reset),
		.conv_req (conv_req),
		.lat      (lat),
		.base     (base),
		.conv_rsp (conv_rsp)
	);

	// ********************************************************************
	// checking helpers
	// ********************************************************************
	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict();
		if (error_cnt == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ********************************************************************
	// register port master
	// ********************************************************************
	// one idle cycle after each access, so a strobe is never set twice
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		bus_s.addr  <= a;
		bus_s.wdata <= d;
		bus_s.wr    <= 1'b1;
		@(posedge core_clk);
		bus_s.wr <= 1'b0;
		@(posedge core_clk);
	endtask

	// the expected word is noted now and compared by the monitor
	task automatic rd(input logic [9:0] a, input logic [15:0] e);
		rd_q.push_back(e);
		bus_s.addr <= a;
		bus_s.rd   <= 1'b1;
		@(posedge core_clk);
		bus_s.rd <= 1'b0;
		@(posedge core_clk);
	endtask

	// ********************************************************************
	// output monitor
	// ********************************************************************
	// read data is looked at only in the cycle after the read strobe
	always @(posedge core_clk) begin
		if (rd_d === 1'b1) begin
			chk("rdata", bus_rdata, rd_q.pop_front());
		end
		if (conv_req.go === 1'b1) begin
			if (pin_q.size() == 0) begin
				chk("go_extra", 16'h0001, 16'h0000);
			end else begin
				chk("pin", 16'(conv_req.pin), 16'(pin_q.pop_front()));
			end
		end
		// the interrupt may only rise once every pin is converted
		if (irq === 1'b1 && irq_d !== 1'b1) begin
			chk("irq_early", 16'(pin_q.size()), 16'h0000);
		end
		rd_d  <= bus_s.rd;
		irq_d <= irq;
	end

	// ********************************************************************
	// one full sweep over group g, interrupt mask m
	// ********************************************************************
	task automatic sweep(input logic [1:0] g, input logic m);
		int                       i;
		logic [`ADCSS_CODE_W-1:0] c;
		base <= 10'($random(seed));
		lat  <= 4'($random(seed));
		// standby bit set so the converter is enabled, ext bit clear, bit 3 and reserved bits kept zero
		wr(`ADCSS_CTRL1_OFS, {6'h08, g});
		// the mask write also gives standby its settle cycle
		wr(`ADCSS_MASK_OFS, {7'h00, m});
		for (i = 0; i <= 2 * g + 1; i++) begin
			pin_q.push_back(i[2:0]);
		end
		wr(`ADCSS_CTRL0_OFS, 8'h50);
		// no control write while converting
		for (i = 0; i < 400 && pin_q.size() != 0; i++) begin
			@(posedge core_clk);
		end
		repeat (24) @(posedge core_clk);
		chk("sweep_len", 16'(pin_q.size()), 16'h0000);
		rd(`ADCSS_CTRL0_OFS, 16'h0010);
		rd(`ADCSS_STAT_OFS, 16'h0001);
		chk("irq", 16'(irq), 16'(m));
		for (i = 0; i <= 2 * g + 1; i++) begin
			c = base + i[9:0];
			rd(`ADCSS_RES_BASE + 10'(2 * i), 16'(c));
		end
		wr(`ADCSS_STAT_OFS, 8'h01);
		@(posedge core_clk);
		chk("irq_clr", 16'(irq), 16'h0000);
	endtask

	// ********************************************************************
	// clock, watchdog and main sequence
	// ********************************************************************
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// the whole run needs well under 2000 cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		error_cnt++;
		print_verdict();
	end

	initial begin
		int g;
		reset = 1'b1;
		bus_s = '0;
		lat   = 4'h0;
		base  = '0;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		// state after reset, plus an unmapped address
		rd(`ADCSS_CTRL0_OFS, 16'h0000);
		rd(`ADCSS_CTRL1_OFS, 16'h0000);
		rd(`ADCSS_STAT_OFS, 16'h0000);
		rd(`ADCSS_RES_BASE, 16'h0000);
		rd(10'h3FF, 16'h0000);
		// frequency bits from both control registers reach the pins
		wr(`ADCSS_CTRL1_OFS, 8'h10);
		wr(`ADCSS_CTRL0_OFS, 8'h80);
		chk("freq_sel", 16'(freq), 16'h0003);
		chk("standby", 16'(stby), 16'h0000);
		// bit 3 of the second register is not built
		wr(`ADCSS_CTRL1_OFS, 8'h08);
		rd(`ADCSS_CTRL1_OFS, 16'h0000);
		// start flag in another mode: stored, nothing converted
		wr(`ADCSS_CTRL1_OFS, 8'h20);
		chk("standby", 16'(stby), 16'h0001);
		wr(`ADCSS_CTRL0_OFS, 8'h40);
		repeat (20) @(posedge core_clk);
		rd(`ADCSS_CTRL0_OFS, 16'h0040);
		wr(`ADCSS_CTRL0_OFS, 8'h00);
		// sweep mode with the converter in standby: nothing converted
		wr(`ADCSS_CTRL1_OFS, 8'h00);
		wr(`ADCSS_CTRL0_OFS, 8'h50);
		repeat (20) @(posedge core_clk);
		rd(`ADCSS_CTRL0_OFS, 16'h0050);
		wr(`ADCSS_CTRL0_OFS, 8'h00);
		// abort while pin 0 is still converting on a slow core
		wr(`ADCSS_CTRL1_OFS, 8'h23);
		wr(`ADCSS_MASK_OFS, 8'h01);
		lat <= 4'hF;
		pin_q.push_back(3'h0);
		wr(`ADCSS_CTRL0_OFS, 8'h50);
		wr(`ADCSS_CTRL0_OFS, 8'h10);
		repeat (40) @(posedge core_clk);
		rd(`ADCSS_STAT_OFS, 16'h0000);
		chk("irq_abort", 16'(irq), 16'h0000);
		// every group size, one of them with the interrupt masked
		for (g = 0; g < 4; g++) begin
			sweep(g[1:0], g != 1);
		end
		repeat (4) @(posedge core_clk);
		print_verdict();
	end
endmodule
